//--- rtl/ckgc_ctrl.v
// strap latch, power-down input and serial register port of the clock generator
`timescale 1ns/1ps
`include "ckgc_defs.vh"

module ckgc_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // strap and strobe pins
  input wire power_good_strobe_pin,
  input wire freq_sel_bit0,
  input wire freq_sel_bit1,
  input wire freq_sel_bit2,
  input wire proc_output_select_strap,
  // serial pins, sda is open drain
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe,
  // latched strap results and power-down request
  output reg strapsLatched,
  output reg [2:0] freqSel,
  output wire cpu100Sel,
  output wire cpu133Sel,
  output wire freqReserved,
  output reg testMode,
  output reg testDriveRefDiv,
  output wire testOutputsHiZ,
  output reg third_processor_clock,
  output wire eighth_serial_ref_clock,
  output reg power_down_request,
  // register image for the clock outputs
  output wire [63:0] ctrlRegs
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  wire [5:0] pinLevel;
  wire pgLevel;
  wire sclS;
  wire sdaS;
  wire [2:0] fsLevel;
  wire outSelLevel;

  ckgc_pin_sync pinSync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pinIn({proc_output_select_strap, freq_sel_bit2, freq_sel_bit1, freq_sel_bit0,
      sdaIn, sclIn}),
    .pinLevel(pinLevel)
  );

  assign sclS = pinLevel[0];
  assign sdaS = pinLevel[1];
  assign fsLevel = pinLevel[4:2];
  assign outSelLevel = pinLevel[5];
  assign pgLevel = power_good_strobe_pin;
  // power-good passes its own three flops below so it can be read level-only
  reg pg1;
  reg pg2;
  reg pg3;
  reg pgS;

  // ----------------------------------------------------------------
  // strap latch and power-down
  // ----------------------------------------------------------------
  // strobe is active low; pins idle high after reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pg1 <= 1'b1;
      pg2 <= 1'b1;
      pg3 <= 1'b1;
      pgS <= 1'b1;
    end else begin
      pg1 <= pgLevel;
      pg2 <= pg1;
      pg3 <= pg2;
      if (pg2 == pg3) begin
        pgS <= pg3;
      end
    end
  end

  // capture while strobe low; test mode keeps the latch transparent
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strapsLatched <= 1'b0;
      freqSel <= 3'b000;
      testMode <= 1'b0;
      testDriveRefDiv <= 1'b0;
      third_processor_clock <= 1'b0;
      power_down_request <= 1'b0;
    end else begin
      if (!pgS && (!strapsLatched || testMode)) begin // [RULE1] [RULE3] [RULE4]
        strapsLatched <= 1'b1;
        freqSel <= fsLevel;
        testMode <= fsLevel[2]; // [RULE17]
        testDriveRefDiv <= fsLevel[1]; // [RULE18]
        third_processor_clock <= outSelLevel; // [RULE19]
      end
      // pin turns into a live power-down level once the strobe has fired
      power_down_request <= strapsLatched & pgS; // [RULE2]
    end
  end

  assign cpu100Sel = strapsLatched && (freqSel == `CKGC_FS_CPU100); // [RULE5]
  assign cpu133Sel = strapsLatched && (freqSel == `CKGC_FS_CPU133); // [RULE5]
  assign freqReserved = strapsLatched && !cpu100Sel && !cpu133Sel; // [RULE5]
  assign testOutputsHiZ = testMode & ~testDriveRefDiv; // [RULE18]
  assign eighth_serial_ref_clock = strapsLatched & ~third_processor_clock; // [RULE19]

  // ----------------------------------------------------------------
  // register bytes
  // ----------------------------------------------------------------
  localparam [63:0] REG_DEFAULTS = {`CKGC_BYTE7_RST, `CKGC_BYTE6_RST, `CKGC_BYTE5_RST,
    `CKGC_BYTE4_RST, `CKGC_BYTE3_RST, `CKGC_BYTE2_RST, `CKGC_BYTE1_RST, `CKGC_BYTE0_RST};

  reg wrStrobe;
  reg [2:0] wrIndex;
  reg [7:0] wrData;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : regByte
      reg [7:0] value;
      // defaults at reset so the clocks run with no serial access
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          value <= REG_DEFAULTS[g*8 +: 8]; // [RULE6]
        end else if (wrStrobe && (wrIndex == g)) begin
          value <= wrData;
        end
      end
      assign ctrlRegs[g*8 +: 8] = value;
    end
  endgenerate

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_CMD = 3'd2;
  localparam [2:0] ST_CNT = 3'd3;
  localparam [2:0] ST_WDATA = 3'd4;
  localparam [2:0] ST_RDATA = 3'd5;
  localparam [2:0] ST_ACKOUT = 3'd6;
  localparam [2:0] ST_ACKIN = 3'd7;

  reg [2:0] state;
  reg [2:0] afterAck;
  reg sclPrev;
  reg sdaPrev;
  reg [6:0] rxShift;
  reg [7:0] txShift;
  reg [2:0] bitCnt;
  reg ackPending;
  reg blockMode;
  reg countSent;
  reg [6:0] ptr;

  wire sclRise = sclS & ~sclPrev;
  wire sclFall = ~sclS & sclPrev;
  wire startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopCond = sclS & sclPrev & ~sdaPrev & sdaS;
  wire [7:0] rxByte = {rxShift, sdaS};
  wire inRange = ptr < `CKGC_REG_COUNT;
  wire [7:0] regRead = inRange ? ctrlRegs[ptr[2:0]*8 +: 8] : 8'h00;
  // block reads lead with the byte count, then data from byte 0
  wire [7:0] nextTx = (blockMode && !countSent) ? `CKGC_REG_COUNT : regRead; // [RULE9]
  wire loadAdvance = !(blockMode && !countSent);

  assign sdaOut = 1'b0; // open drain: only ever pulls low

  // one transfer engine; writes land per byte so a stop anywhere keeps them
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      afterAck <= ST_IDLE;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      rxShift <= 7'h00;
      txShift <= 8'h00;
      bitCnt <= 3'd0;
      ackPending <= 1'b0;
      blockMode <= 1'b0;
      countSent <= 1'b0;
      ptr <= 7'h00;
      sdaOe <= 1'b0;
      wrStrobe <= 1'b0;
      wrIndex <= 3'd0;
      wrData <= 8'h00;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
      wrStrobe <= 1'b0;
      if (startCond) begin // [RULE15]
        state <= ST_ADDR;
        bitCnt <= 3'd0;
        ackPending <= 1'b0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin // [RULE10]
        state <= ST_IDLE;
        ackPending <= 1'b0;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_CMD, ST_CNT, ST_WDATA: begin
            if (sclRise) begin
              rxShift <= rxByte[6:0];
              bitCnt <= bitCnt + 3'd1;
              if (bitCnt == 3'd7) begin
                ackPending <= 1'b1;
                case (state)
                  ST_ADDR: begin
                    if (rxByte[7:1] != `CKGC_SLAVE_ADDR7) begin // [RULE14]
                      ackPending <= 1'b0;
                      state <= ST_IDLE;
                    end else if (rxByte[0]) begin
                      afterAck <= ST_RDATA; // [RULE8]
                      txShift <= nextTx;
                      countSent <= 1'b1;
                      if (loadAdvance) begin
                        ptr <= ptr + 7'd1;
                      end
                    end else begin
                      afterAck <= ST_CMD;
                    end
                  end
                  ST_CMD: begin
                    blockMode <= ~rxByte[`CKGC_CMD_SINGLE_BIT]; // [RULE12]
                    countSent <= 1'b0;
                    // block accesses always begin at byte 0
                    ptr <= rxByte[`CKGC_CMD_SINGLE_BIT] ? rxByte[6:0] : 7'h00; // [RULE11]
                    afterAck <= rxByte[`CKGC_CMD_SINGLE_BIT] ? ST_WDATA : ST_CNT; // [RULE16]
                  end
                  ST_CNT: begin
                    afterAck <= ST_WDATA; // [RULE16]
                  end
                  default: begin
                    afterAck <= ST_WDATA;
                    wrStrobe <= inRange; // [RULE10]
                    wrIndex <= ptr[2:0];
                    wrData <= rxByte;
                    ptr <= ptr + 7'd1; // [RULE9]
                  end
                endcase
              end
            end else if (sclFall && ackPending) begin
              ackPending <= 1'b0;
              state <= ST_ACKOUT;
              sdaOe <= 1'b1;
            end
          end
          ST_ACKOUT: begin
            if (sclFall) begin
              state <= afterAck;
              bitCnt <= 3'd0;
              sdaOe <= (afterAck == ST_RDATA) ? ~txShift[7] : 1'b0; // [RULE9]
            end
          end
          ST_RDATA: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 3'd1;
            end else if (sclFall) begin
              if (bitCnt == 3'd0) begin
                // byte done: release for the host acknowledge
                state <= ST_ACKIN;
                sdaOe <= 1'b0;
              end else begin
                txShift <= {txShift[6:0], 1'b0};
                sdaOe <= ~txShift[6];
              end
            end
          end
          ST_ACKIN: begin
            if (sclRise) begin
              if (sdaS) begin
                state <= ST_IDLE; // not acknowledged: read ends
              end else begin
                txShift <= nextTx;
                countSent <= 1'b1;
                if (loadAdvance) begin
                  ptr <= ptr + 7'd1;
                end
              end
            end else if (sclFall) begin
              state <= ST_RDATA;
              bitCnt <= 3'd0;
              sdaOe <= ~txShift[7];
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // ckgc_ctrl

//--- rtl/ckgc_defs.vh
// constants for the clock generator strap latch and serial control port
//
// Contract
// (RULE1) power-good pin is a level strobe latching frequency, test and output-select straps.
// (RULE2) after power-good goes low, a high on that pin requests power-down.
// (RULE3) host settles frequency straps first; device samples them when power-good seen low.
// (RULE4) outside test mode capture fires once; later pin and strap changes are ignored.
// (RULE5) code 101 gives 100 MHz processor clock, 001 gives 133 MHz; others reserved.
// (RULE6) all serial registers load defaults at power-up; serial access is optional.
// (RULE7) host changes registers at init only, never for run-time power management.
// (RULE8) slave accepts byte write, byte read, block write and block read.
// (RULE9) block bytes go lowest first, each byte most significant bit first.
// (RULE10) host may stop a block after any whole byte; completed bytes take effect.
// (RULE11) single-byte accesses address the register byte indexed by the command byte.
// (RULE12) command bit 7 zero means block access, one means single-byte access.
// (RULE13) command bits 6..0 hold byte offset; host sends zeros for block accesses.
// (RULE14) slave answers only address byte 1101001x (D2h write, D3h read).
// (RULE15) each transfer opens start, address, write bit, ack, command, ack.
// (RULE16) block write sends a byte count after the command; slave acks count and data.
// (RULE17) test-select strap high at power-good assertion enters test mode.
// (RULE18) in test mode the test-output strap picks tri-state (0) or divided reference (1).
// (RULE19) output-select strap 1 gives third processor clock, 0 gives eighth serial clock.
`ifndef CKGC_DEFS_VH
`define CKGC_DEFS_VH

// ----------------------------------------------------------------
// serial port
// ----------------------------------------------------------------
`define CKGC_SLAVE_ADDR7 7'h69
`define CKGC_CMD_SINGLE_BIT 7
`define CKGC_REG_COUNT 8'h08
`define CKGC_IDX_BITS 7

// ----------------------------------------------------------------
// register reset values, byte 0 upward
// ----------------------------------------------------------------
`define CKGC_BYTE0_RST 8'hFF
`define CKGC_BYTE1_RST 8'hF6
`define CKGC_BYTE2_RST 8'hFF
`define CKGC_BYTE3_RST 8'h00
`define CKGC_BYTE4_RST 8'h00
`define CKGC_BYTE5_RST 8'h00
`define CKGC_BYTE6_RST 8'h00
`define CKGC_BYTE7_RST 8'h00

// ----------------------------------------------------------------
// frequency strap codes {bit2,bit1,bit0}
// ----------------------------------------------------------------
`define CKGC_FS_CPU100 3'b101
`define CKGC_FS_CPU133 3'b001

// ----------------------------------------------------------------
// pin synchroniser idle level
// ----------------------------------------------------------------
`define CKGC_SYNC_WIDTH 6
`define CKGC_SYNC_RST 6'h3F

`endif

//--- rtl/ckgc_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "ckgc_defs.vh"

module ckgc_pin_sync (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // pins and filtered levels
  input wire [`CKGC_SYNC_WIDTH-1:0] pinIn,
  output wire [`CKGC_SYNC_WIDTH-1:0] pinLevel
);

  genvar g;
  generate
    for (g = 0; g < `CKGC_SYNC_WIDTH; g = g + 1) begin : bitSync
      reg stage1;
      reg stage2;
      reg stage3;
      reg level;
      // stage1 feeds only stage2; level moves once stages 2 and 3 agree
      always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          stage1 <= 1'b1;
          stage2 <= 1'b1;
          stage3 <= 1'b1;
          level <= 1'b1;
        end else begin
          stage1 <= pinIn[g];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            level <= stage3;
          end
        end
      end
      assign pinLevel[g] = level;
    end
  endgenerate

endmodule // ckgc_pin_sync

//--- verif/ckgc_ctrl_chk.sv
// assertion checker for the strap latch and serial port
`timescale 1ns/1ps
module ckgc_ctrl_chk (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // pins
  input wire power_good_strobe_pin,
  input wire sclIn,
  input wire sdaOe,
  // strap results, power-down request and register image
  input wire strapsLatched,
  input wire [2:0] freqSel,
  input wire cpu100Sel,
  input wire cpu133Sel,
  input wire freqReserved,
  input wire testMode,
  input wire testDriveRefDiv,
  input wire testOutputsHiZ,
  input wire third_processor_clock,
  input wire eighth_serial_ref_clock,
  input wire power_down_request,
  input wire [63:0] ctrlRegs
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // strap latch, power-down, register defaults and sda timing
  // ----------------------------------------
  a_capture_once: assert property (
    strapsLatched && !testMode |=> strapsLatched && $stable(freqSel))
    else $error("capture moved after first strobe");
  // eight lows cover the pin filter with margin
  a_strobe_latch: assert property (
    !power_good_strobe_pin [*8] |-> strapsLatched && !power_down_request)
    else $error("strobe low did not latch");
  a_pwrdn_level: assert property (
    (strapsLatched && power_good_strobe_pin) [*8] |-> power_down_request)
    else $error("power-down not raised");
  a_pwrdn_after_cap: assert property (power_down_request |-> strapsLatched)
    else $error("power-down before capture");
  a_speed_decode: assert property (
    cpu100Sel == (strapsLatched && freqSel == 3'b101)
    && cpu133Sel == (strapsLatched && freqSel == 3'b001))
    else $error("speed decode wrong");
  a_code_reserved: assert property (
    freqReserved == (strapsLatched && freqSel != 3'b101 && freqSel != 3'b001))
    else $error("reserved decode wrong");
  a_out_share: assert property (
    strapsLatched |-> eighth_serial_ref_clock == !third_processor_clock)
    else $error("shared output select wrong");
  a_test_hiz: assert property (
    testOutputsHiZ == (testMode && !testDriveRefDiv))
    else $error("test tri-state wrong");
  a_reg_default: assert property (
    $rose(resetn) |-> ctrlRegs == 64'h0000_0000_00FF_F6FF)
    else $error("register defaults wrong");
  // slave may only move sda while the host holds scl low
  a_sda_on_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda moved with scl high");
  c_latched: cover property ($rose(strapsLatched));
  c_test: cover property ($rose(testMode));
  c_pwrdn: cover property ($rose(power_down_request));
  c_ack: cover property ($rose(sdaOe));
endmodule // ckgc_ctrl_chk

//--- verif/ckgc_smbus_host.sv
// serial bus host model driving the control port pins
`timescale 1ns/1ps
module ckgc_smbus_host (
  // clock
  input wire clk_sys,
  // bus pins
  input wire sdaOe,
  output reg sclIn,
  output wire sdaIn
);
  reg hostLow;
  // open drain with pull-up: high unless a party pulls low
  assign sdaIn = ~(hostLow | sdaOe);
  initial begin
    sclIn = 1'b1;
    hostLow = 1'b0;
  end
  // ----------------------------------------
  // bus steps, each held 9 cycles for the pin filter
  // ----------------------------------------
  task step(input logic s, input logic l);
    @(posedge clk_sys);
    sclIn <= s;
    hostLow <= l;
    repeat (8) @(posedge clk_sys);
  endtask
  // start or repeated start; scl never falls with sda moving
  task start();
    step(1'b0, hostLow);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task stop();
    step(1'b0, hostLow);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // eight bits msb first then the ninth, wire sampled with scl high
  task xfer(input logic [8:0] d, output logic [8:0] q);
    integer i;
    for (i = 8; i >= 0; i--) begin
      step(1'b0, hostLow);
      step(1'b0, !d[i]);
      step(1'b1, !d[i]);
      q[i] = sdaIn;
    end
  endtask
endmodule // ckgc_smbus_host

//--- verif/clock_gen_strap_and_smbus_control_tb.sv
// testbench for the clock generator strap latch and serial port
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t mismatch", $time); end end
module clock_gen_strap_and_smbus_control_tb;
  reg clk_sys;
  reg resetn;
  reg power_good_strobe_pin;
  reg [2:0] fsPins;
  reg selPin;
  wire sdaDrv;
  wire sclIn, sdaIn, sdaOe, strapsLatched, cpu100Sel, cpu133Sel, freqReserved, testMode;
  wire testDriveRefDiv, testOutputsHiZ, third_processor_clock, eighth_serial_ref_clock;
  wire power_down_request;
  wire [2:0] freqSel;
  wire [63:0] ctrlRegs;
  integer n_errors, check_count, i;
  reg [8:0] q;
  ckgc_ctrl ckgc_ctrl_i (.clk_sys, .resetn, .power_good_strobe_pin,
    .freq_sel_bit0(fsPins[0]), .freq_sel_bit1(fsPins[1]), .freq_sel_bit2(fsPins[2]),
    .proc_output_select_strap(selPin), .sclIn, .sdaIn, .sdaOut(sdaDrv), .sdaOe,
    .strapsLatched, .freqSel, .cpu100Sel, .cpu133Sel, .freqReserved, .testMode,
    .testDriveRefDiv, .testOutputsHiZ, .third_processor_clock, .eighth_serial_ref_clock,
    .power_down_request, .ctrlRegs);
  ckgc_smbus_host ckgc_smbus_host_i (.clk_sys, .sdaOe, .sclIn, .sdaIn);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // reset with straps settled, then drop the strobe
  task capture(input logic [2:0] c);
    @(posedge clk_sys);
    resetn <= 1'b0;
    power_good_strobe_pin <= 1'b1;
    fsPins <= c;
    // output-select strap decoupled from any single frequency strap
    selPin <= c[0] ^ c[1];
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK(strapsLatched, 1'b0)
    power_good_strobe_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK(freqSel, c)
    `CHK(cpu100Sel, c == 3'b101)
    `CHK(cpu133Sel, c == 3'b001)
    `CHK(testMode, c[2])
    `CHK(testOutputsHiZ, c[2] & ~c[1])
    `CHK(testDriveRefDiv, c[1])
    `CHK(strapsLatched, 1'b1)
    `CHK(freqReserved, c != 3'b101 && c != 3'b001)
    `CHK(third_processor_clock, c[0] ^ c[1])
    `CHK(eighth_serial_ref_clock, ~(c[0] ^ c[1]))
    `CHK(power_down_request, 1'b0)
  endtask
  task wr(input logic [7:0] b, input logic ack);
    ckgc_smbus_host_i.xfer({b, 1'b1}, q);
    `CHK(q[0], ack)
  endtask
  task rd(input logic [7:0] b, input logic last);
    ckgc_smbus_host_i.xfer({8'hFF, last}, q);
    `CHK(q[8:1], b)
  endtask
  // command phase, optionally turned round for a read
  task cmd(input logic [7:0] c, input logic rdx);
    ckgc_smbus_host_i.start();
    wr(8'hD2, 1'b0);
    wr(c, 1'b0);
    if (rdx) begin
      ckgc_smbus_host_i.start();
      wr(8'hD3, 1'b0);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_errors = 0;
    check_count = 0;
    resetn = 1'b0;
    power_good_strobe_pin = 1'b1;
    fsPins = 3'b000;
    selPin = 1'b0;
    for (i = 0; i < 8; i++) capture(i[2:0]);
    // last capture outside test mode, where the one-shot must hold
    capture(3'b001);
    `CHK(ctrlRegs, 64'h0000_0000_00FF_F6FF)
    `CHK(sdaDrv, 1'b0)
    // pin now means power-down; later strap moves must not land
    power_good_strobe_pin <= 1'b1;
    fsPins <= 3'b101;
    selPin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK(power_down_request, 1'b1)
    power_good_strobe_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK(freqSel, 3'b001)
    `CHK(testMode, 1'b0)
    `CHK(third_processor_clock, 1'b1)
    `CHK(power_down_request, 1'b0)
    // register changes only while the system is still initialising
    cmd(8'h83, 1'b0);
    wr(8'h5A, 1'b0);
    ckgc_smbus_host_i.stop();
    `CHK(ctrlRegs[31:24], 8'h5A)
    cmd(8'h83, 1'b1);
    rd(8'h5A, 1'b1);
    ckgc_smbus_host_i.stop();
    // block write with byte count two, then stop after both data bytes
    cmd(8'h00, 1'b0);
    wr(8'h02, 1'b0);
    wr(8'hA1, 1'b0);
    wr(8'hB2, 1'b0);
    ckgc_smbus_host_i.stop();
    `CHK(ctrlRegs[23:0], 24'hFF_B2A1)
    cmd(8'h00, 1'b1);
    rd(8'h08, 1'b0);
    rd(8'hA1, 1'b0);
    rd(8'hB2, 1'b0);
    rd(8'hFF, 1'b0);
    rd(8'h5A, 1'b1);
    ckgc_smbus_host_i.stop();
    // foreign address gets no ack and changes nothing
    ckgc_smbus_host_i.start();
    wr(8'hD4, 1'b1);
    wr(8'h85, 1'b1);
    ckgc_smbus_host_i.stop();
    `CHK(ctrlRegs[47:40], 8'h00)
    stop_test();
  end
  // hang guard
  initial begin
    repeat (50000) @(posedge clk_sys);
    n_errors++;
    $display("BAD %0t run too long", $time);
    stop_test();
  end
endmodule // clock_gen_strap_and_smbus_control_tb
bind ckgc_ctrl ckgc_ctrl_chk ckgc_ctrl_chk_i (.clk_sys, .resetn, .power_good_strobe_pin,
  .sclIn, .sdaOe, .strapsLatched, .freqSel, .cpu100Sel, .cpu133Sel, .freqReserved,
  .testMode, .testDriveRefDiv, .testOutputsHiZ, .third_processor_clock,
  .eighth_serial_ref_clock, .power_down_request, .ctrlRegs);
